// ===== fsn_pkg.sv
// shared constants and types of the float subtract and negate unit
package fsn_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_AC_BASE = 8'h00;
    localparam logic [7:0] ADDR_AC_LAST = 8'h1C;
    localparam logic [7:0] ADDR_SRC_HI = 8'h20;
    localparam logic [7:0] ADDR_SRC_LO = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_INSN = 8'h2C;
    localparam logic [7:0] ADDR_TRAP = 8'h30;

    // ****************************************
    // float status register fields
    // ****************************************
    localparam int FPS_CARRY = 0;
    localparam int FPS_OVERFLOW = 1;
    localparam int FPS_ZERO = 2;
    localparam int FPS_NEGATIVE = 3;
    localparam int FPS_TRUNCATE = 5;
    localparam int FPS_DOUBLE = 7;
    localparam int FPS_OVF_TRAP_EN = 9;
    localparam int FPS_UNF_TRAP_EN = 10;
    localparam int FPS_UNDEF_TRAP_EN = 11;
    localparam logic [31:0] FPS_RESET = 32'h0000_0000;

    // ****************************************
    // trap register fields and causes
    // ****************************************
    localparam int TRAP_PENDING = 0;
    localparam int TRAP_CAUSE_LSB = 1;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_UNDEF = 2'h1;
    localparam logic [1:0] CAUSE_OVF = 2'h2;
    localparam logic [1:0] CAUSE_UNF = 2'h3;

    // ****************************************
    // instruction word decode
    // ****************************************
    localparam logic [7:0] OPC_SUBTRACT = 8'hF6;
    localparam logic [7:0] OPC_MULTIPLY = 8'hF2;
    localparam logic [9:0] OPC_NEGATE = 10'h3C7;
    localparam logic [2:0] MODE_REGISTER = 3'h0;

    // ****************************************
    // arithmetic constants
    // ****************************************
    localparam logic [10:0] EXP_BIAS = 11'h080;
    localparam logic [10:0] EXP_MAX = 11'h0FF;
    localparam logic [60:0] RND_DBL = 61'h0000_0000_0000_0008;
    localparam logic [60:0] RND_SGL = 61'h0000_0008_0000_0000;
    localparam logic [60:0] KEEP_DBL = 61'h1FFF_FFFF_FFFF_FFF0;
    localparam logic [60:0] KEEP_SGL = 61'h1FFF_FFF0_0000_0000;
    localparam logic [54:0] FRAC_SGL = 55'h7F_FFFF_0000_0000;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic sign;
        logic [7:0] expo;
        logic [54:0] frac;
    } fsn_num_s;

    typedef struct packed {
        logic ovf;
        logic unf;
        fsn_num_s num;
    } fsn_res_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } fsn_state_e;

endpackage

// ===== fsn_unit.sv
// float subtract, negate and multiply unit behind an apb slave
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
module fsn_unit
    import fsn_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trap signalling
    output logic float_trap,
    output logic [1:0] float_trap_cause,
    output logic unit_busy
);

    // ****************************************
    // arithmetic helpers
    // ****************************************
    function automatic logic [5:0] lead_zeros(input logic [59:0] m);
        logic [5:0] n;
        logic found;
        n = 6'h00;
        found = 1'b0;
        for (int i = 59; i >= 0; i--) begin
            if (!found && m[i]) begin
                found = 1'b1;
                n = 6'(59 - i);
            end
        end
        return n;
    endfunction

    function automatic logic [59:0] mant_of(input fsn_num_s x, input logic dbl);
        logic [54:0] f;
        f = dbl ? x.frac : (x.frac & FRAC_SGL);
        if (x.expo == 8'h00) begin
            return 60'h0;
        end
        return {1'b1, f, 4'h0};
    endfunction

    function automatic logic is_minus_zero(input fsn_num_s x);
        return x.sign && (x.expo == 8'h00);
    endfunction

    function automatic fsn_res_s pack_result(input logic sign, input logic [10:0] exp_in,
                                             input logic [59:0] mant, input logic dbl,
                                             input logic trunc);
        fsn_res_s r;
        logic [60:0] ext;
        logic [10:0] e;
        r = '0;
        ext = {1'b0, mant};
        e = exp_in;
        if (!trunc) begin
            ext = ext + (dbl ? RND_DBL : RND_SGL);
        end
        if (ext[60]) begin
            ext = ext >> 1;
            e = e + 11'h001;
        end
        ext = ext & (dbl ? KEEP_DBL : KEEP_SGL);
        if (mant != 60'h0) begin
            r.num.sign = sign;
            r.num.expo = e[7:0];
            r.num.frac = ext[58:4];
            r.ovf = !e[10] && (e > EXP_MAX);
            r.unf = e[10] || (e == 11'h000);
        end
        return r;
    endfunction

    function automatic fsn_res_s sub_core(input fsn_num_s a, input fsn_num_s b,
                                          input logic dbl, input logic trunc);
        logic [59:0] ma;
        logic [59:0] mb;
        logic [59:0] big;
        logic [59:0] sml;
        logic [59:0] nm;
        logic [60:0] sum;
        logic [7:0] eb;
        logic [7:0] sh;
        logic [10:0] e;
        logic sa;
        logic sb;
        logic rs;
        logic swap;
        ma = mant_of(a, dbl);
        mb = mant_of(b, dbl);
        sa = a.sign;
        sb = ~b.sign;
        swap = {b.expo, mb} > {a.expo, ma};
        big = swap ? mb : ma;
        sml = swap ? ma : mb;
        eb = swap ? b.expo : a.expo;
        sh = swap ? (b.expo - a.expo) : (a.expo - b.expo);
        rs = swap ? sb : sa;
        sml = (mb == 60'h0 || ma == 60'h0) ? sml : sml;
        nm = sml >> sh;
        if ((nm << sh) != sml) begin
            nm[0] = 1'b1;
        end
        if (sa == sb) begin
            sum = {1'b0, big} + {1'b0, nm};
        end else begin
            sum = {1'b0, big} - {1'b0, nm};
        end
        e = {3'h0, eb};
        if (sum[60]) begin
            nm = sum[60:1];
            nm[0] = nm[0] | sum[0];
            e = e + 11'h001;
        end else begin
            nm = sum[59:0] << lead_zeros(sum[59:0]);
            e = e - {5'h00, lead_zeros(sum[59:0])};
        end
        return pack_result(rs, e, nm, dbl, trunc);
    endfunction

    function automatic fsn_res_s mul_core(input fsn_num_s a, input fsn_num_s b,
                                          input logic dbl, input logic trunc);
        logic [55:0] ma;
        logic [55:0] mb;
        logic [111:0] prod;
        logic [59:0] nm;
        logic [10:0] e;
        ma = 56'(mant_of(a, dbl) >> 4);
        mb = 56'(mant_of(b, dbl) >> 4);
        prod = ma * mb;
        e = {3'h0, a.expo} + {3'h0, b.expo} - EXP_BIAS;
        if (prod[111]) begin
            nm = prod[111:52];
            nm[0] = nm[0] | (|prod[51:0]);
        end else begin
            nm = prod[110:51];
            nm[0] = nm[0] | (|prod[50:0]);
            e = e - 11'h001;
        end
        return pack_result(a.sign ^ b.sign, e, nm, dbl, trunc);
    endfunction

    // ****************************************
    // state
    // ****************************************
    fsn_num_s acc [4];
    fsn_num_s next_acc [4];
    fsn_num_s src_op;
    fsn_num_s next_src_op;
    logic [31:0] float_status_register;
    logic [31:0] next_fps;
    logic [15:0] insn;
    logic [15:0] next_insn;
    fsn_state_e state;
    fsn_state_e next_state;
    logic trap_pending;
    logic next_trap_pending;
    logic [1:0] next_float_trap_cause;
    logic next_float_trap;
    logic next_unit_busy;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // ****************************************
    // bus decode
    // ****************************************
    logic access;
    logic wr_done;
    logic acc_hit;
    logic mapped;
    logic insn_ok;
    logic [31:0] rd_mux;

    always_comb begin
        access = psel && penable;
        wr_done = access && pready && pwrite;
        acc_hit = paddr <= ADDR_AC_LAST && paddr[1:0] == 2'h0;
        mapped = acc_hit || paddr == ADDR_SRC_HI || paddr == ADDR_SRC_LO
            || paddr == ADDR_STATUS || paddr == ADDR_INSN || paddr == ADDR_TRAP;
        insn_ok = pwdata[15:8] == OPC_SUBTRACT || pwdata[15:8] == OPC_MULTIPLY
            || pwdata[15:6] == OPC_NEGATE;
        rd_mux = 32'h0000_0000;
        if (acc_hit) begin
            rd_mux = paddr[2] ? acc[paddr[4:3]][31:0] : acc[paddr[4:3]][63:32];
        end else if (paddr == ADDR_SRC_HI) begin
            rd_mux = src_op[63:32];
        end else if (paddr == ADDR_SRC_LO) begin
            rd_mux = src_op[31:0];
        end else if (paddr == ADDR_STATUS) begin
            rd_mux = float_status_register;
        end else if (paddr == ADDR_INSN) begin
            rd_mux = {15'h0000, unit_busy, insn};
        end else if (paddr == ADDR_TRAP) begin
            rd_mux = {29'h0000_0000, float_trap_cause, trap_pending};
        end
        next_pready = access && !pready;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (access && !pready) begin
            next_prdata = pwrite ? 32'h0000_0000 : rd_mux;
            next_pslverr = !mapped || (pwrite && paddr == ADDR_INSN && !insn_ok);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************
    // execution
    // ****************************************
    always_comb begin
        fsn_num_s opa;
        fsn_num_s opb;
        fsn_res_s res;
        logic [1:0] ai;
        logic dst_acc;
        logic src_acc;
        logic fault;
        opa = '0;
        opb = '0;
        res = '0;
        ai = insn[7:6];
        dst_acc = insn[5:3] == MODE_REGISTER && !insn[2];
        src_acc = dst_acc;
        fault = 1'b0;
        next_acc = acc;
        next_src_op = src_op;
        next_fps = float_status_register;
        next_insn = insn;
        next_state = state;
        next_trap_pending = trap_pending;
        next_float_trap_cause = float_trap_cause;
        next_float_trap = 1'b0;
        if (wr_done) begin
            if (acc_hit && paddr[2]) begin
                next_acc[paddr[4:3]][31:0] = pwdata;
            end else if (acc_hit) begin
                next_acc[paddr[4:3]][63:32] = pwdata;
            end else if (paddr == ADDR_SRC_HI) begin
                next_src_op[63:32] = pwdata;
            end else if (paddr == ADDR_SRC_LO) begin
                next_src_op[31:0] = pwdata;
            end else if (paddr == ADDR_STATUS) begin
                next_fps = pwdata & 32'h0000_0EAF;
            end else if (paddr == ADDR_TRAP && pwdata[TRAP_PENDING]) begin
                next_trap_pending = 1'b0;
            end
        end
        unique case (state)
            ST_IDLE: begin
                if (wr_done && paddr == ADDR_INSN && insn_ok) begin
                    next_insn = pwdata[15:0];
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_IDLE;
                if (insn[15:6] == OPC_NEGATE) begin
                    opa = dst_acc ? acc[insn[1:0]] : src_op;
                    if (opa.expo != 8'h00) begin
                        res.num = {~opa.sign, opa.expo, opa.frac};
                    end
                    if (dst_acc) begin
                        next_acc[insn[1:0]] = res.num;
                    end else begin
                        next_src_op = res.num;
                    end
                    next_fps[FPS_CARRY] = 1'b0;
                    next_fps[FPS_OVERFLOW] = 1'b0;
                    next_fps[FPS_ZERO] = res.num.expo == 8'h00;
                    next_fps[FPS_NEGATIVE] = res.num.sign;
                    if (float_status_register[FPS_UNDEF_TRAP_EN] && is_minus_zero(opa)) begin
                        next_float_trap = 1'b1;
                        next_float_trap_cause = CAUSE_UNDEF;
                    end
                end else begin
                    opa = acc[ai];
                    opb = src_acc ? acc[insn[1:0]] : src_op;
                    if (float_status_register[FPS_UNDEF_TRAP_EN] && is_minus_zero(opb)) begin
                        next_float_trap = 1'b1;
                        next_float_trap_cause = CAUSE_UNDEF;
                    end else begin
                        if (insn[15:8] == OPC_MULTIPLY) begin
                            res = mul_core(opa, opb, float_status_register[FPS_DOUBLE], float_status_register[FPS_TRUNCATE]);
                        end else begin
                            res = sub_core(opa, opb, float_status_register[FPS_DOUBLE], float_status_register[FPS_TRUNCATE]);
                        end
                        if (res.unf && !float_status_register[FPS_UNF_TRAP_EN]) begin
                            res.num = '0;
                        end else if (res.unf) begin
                            fault = 1'b1;
                            next_float_trap_cause = CAUSE_UNF;
                        end
                        if (res.ovf && !float_status_register[FPS_OVF_TRAP_EN]) begin
                            res.num = '0;
                        end else if (res.ovf) begin
                            fault = 1'b1;
                            next_float_trap_cause = CAUSE_OVF;
                        end
                        next_acc[ai] = res.num;
                        next_float_trap = fault;
                        next_fps[FPS_CARRY] = 1'b0;
                        next_fps[FPS_OVERFLOW] = res.ovf;
                        next_fps[FPS_ZERO] = res.num.expo == 8'h00;
                        next_fps[FPS_NEGATIVE] = res.num.sign;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (next_float_trap) begin
            next_trap_pending = 1'b1;
        end
        next_unit_busy = next_state == ST_EXEC;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                acc[i] <= '0;
            end
            src_op <= '0;
            float_status_register <= FPS_RESET;
            insn <= 16'h0000;
            state <= ST_IDLE;
            trap_pending <= 1'b0;
            float_trap_cause <= CAUSE_NONE;
            float_trap <= 1'b0;
            unit_busy <= 1'b0;
        end else begin
            acc <= next_acc;
            src_op <= next_src_op;
            float_status_register <= next_fps;
            insn <= next_insn;
            state <= next_state;
            trap_pending <= next_trap_pending;
            float_trap_cause <= next_float_trap_cause;
            float_trap <= next_float_trap;
            unit_busy <= next_unit_busy;
        end
    end

endmodule

// ===== fsn_unit_properties.sv
// concurrent checks on the ports of the float subtract and negate unit
`timescale 1ns/100ps
module fsn_unit_properties
    import fsn_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // trap signalling
    input wire logic float_trap,
    input wire logic [1:0] float_trap_cause,
    input wire logic unit_busy
);
    // ****************************************
    // properties
    // ****************************************
    logic wr_insn;
    assign wr_insn = psel && penable && pready && pwrite && paddr == ADDR_INSN && !pslverr;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence
    sequence s_exec;
        unit_busy ##1 !unit_busy;
    endsequence
    AST_ONE_WAIT: assert property (psel && !penable |=> s_one_wait)
        else $error("apb answer not in second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (psel && !penable && paddr > ADDR_TRAP
        |=> ##1 (pslverr && prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_EXEC: assert property (wr_insn && !unit_busy |=> s_exec)
        else $error("instruction did not execute for one cycle");
    AST_TRAP_ORIGIN: assert property (float_trap |-> $past(unit_busy))
        else $error("trap without an execute cycle before it");
    AST_TRAP_PULSE: assert property (float_trap |=> !float_trap)
        else $error("trap pulse longer than one cycle");
    AST_CAUSE_SET: assert property (float_trap |-> float_trap_cause != CAUSE_NONE)
        else $error("trap with no cause");
    AST_CAUSE_HOLD: assert property (!float_trap |-> $stable(float_trap_cause))
        else $error("trap cause changed without a trap");
    AST_NEG_EXACT: assert property (wr_insn && pwdata[15:6] == OPC_NEGATE
        |=> ##1 (!float_trap || float_trap_cause == CAUSE_UNDEF))
        else $error("negate flagged overflow or underflow");
endmodule
bind fsn_unit fsn_unit_properties i_fsn_unit_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .float_trap(float_trap), .float_trap_cause(float_trap_cause), .unit_busy(unit_busy)
);

// ===== fsn_core_model.sv
// apb master standing in for the processor core
`timescale 1ns/100ps
module fsn_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end
    // one transfer: setup, then access until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// ===== fsn_unit_tb.sv
// self-checking testbench of the float subtract and negate unit
`timescale 1ns/100ps
module fsn_unit_tb
    import fsn_pkg::*;
;
    `define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
    // ****************************************
    // signals and table
    // ****************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, float_trap, unit_busy, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] float_trap_cause;
    logic [1:0] exp_cause;
    int num_errors, n_tests, n_trap;
    typedef struct packed {
        logic [15:0] insn;
        logic [11:0] st;
        logic [31:0] ah, sh, eh, el;
        logic [3:0] ef;
        logic [2:0] et;
    } fsn_row_s;
    fsn_row_s rows [18] = '{
        '{16'hF608, 12'h001, 32'h4140_0000, 32'h4080_0000, 32'h4100_0000, 32'h0, 4'h0, 3'h0},
        '{16'hF648, 12'h000, 32'h4080_0000, 32'h4140_0000, 32'hC100_0000, 32'h0, 4'h8, 3'h0},
        '{16'hF688, 12'h000, 32'h4080_0000, 32'h4080_0000, 32'h0, 32'h0, 4'h4, 3'h0},
        '{16'hF6C8, 12'h000, 32'h4080_0000, 32'hC080_0000, 32'h4100_0000, 32'h0, 4'h0, 3'h0},
        '{16'hF608, 12'h000, 32'h7F80_0000, 32'hFF80_0000, 32'h0, 32'h0, 4'h6, 3'h0},
        '{16'hF608, 12'h200, 32'h7F80_0000, 32'hFF80_0000, 32'h0, 32'h0, 4'h6, 3'h5},
        '{16'hF608, 12'h000, 32'h00C0_0000, 32'h00A0_0000, 32'h0, 32'h0, 4'h4, 3'h0},
        '{16'hF608, 12'h400, 32'h00C0_0000, 32'h00A0_0000, 32'h7F80_0000, 32'h0, 4'h0, 3'h7},
        '{16'hF608, 12'h800, 32'h4080_0000, 32'h8000_0000, 32'h4080_0000, 32'h0, 4'h0, 3'h3},
        '{16'hF608, 12'h020, 32'h4080_0000, 32'h3400_0000, 32'h407F_FFFF, 32'h0, 4'h0, 3'h0},
        '{16'hF608, 12'h000, 32'h4080_0000, 32'h3400_0000, 32'h4080_0000, 32'h0, 4'h0, 3'h0},
        '{16'hF608, 12'h080, 32'h4080_0000, 32'h3400_0000, 32'h407F_FFFF, 32'h8000_0000,
          4'h0, 3'h0},
        '{16'hF1C0, 12'h003, 32'h4080_0000, 32'h0, 32'hC080_0000, 32'h0, 4'h8, 3'h0},
        '{16'hF1C1, 12'h000, 32'hC100_0000, 32'h0, 32'h4100_0000, 32'h0, 4'h0, 3'h0},
        '{16'hF1C2, 12'h000, 32'h0, 32'h0, 32'h0, 32'h0, 4'h4, 3'h0},
        '{16'hF1C3, 12'h000, 32'h8000_0000, 32'h0, 32'h0, 32'h0, 4'h4, 3'h0},
        '{16'hF208, 12'h000, 32'h4100_0000, 32'h40C0_0000, 32'h4140_0000, 32'h0, 4'h0, 3'h0},
        '{16'hF1C0, 12'h800, 32'h8000_0000, 32'h0, 32'h0, 32'h0, 4'h4, 3'h3}
    };
    fsn_unit i_fsn_unit (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .float_trap(float_trap), .float_trap_cause(float_trap_cause), .unit_busy(unit_busy)
    );
    fsn_core_model i_fsn_core_model (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    // ****************************************
    // tasks
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (float_trap === 1'b1) n_trap++;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_fsn_core_model.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        i_fsn_core_model.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic run_row(input fsn_row_s r);
        logic [7:0] ab;
        int t0;
        ab = {3'h0, (r.insn[15:6] == OPC_NEGATE) ? r.insn[1:0] : r.insn[7:6], 3'h0};
        wr(ADDR_TRAP, 32'h1);
        wr(ab, r.ah);
        wr(ab + 8'h04, 32'h0);
        wr(ADDR_SRC_HI, r.sh);
        wr(ADDR_SRC_LO, 32'h0);
        wr(ADDR_STATUS, {20'h0, r.st});
        t0 = n_trap;
        wr(ADDR_INSN, {16'h0, r.insn});
        `CHK("insn refused", 1'b0, e);
        rd(ab);
        `CHK("acc high", r.eh, q);
        rd(ab + 8'h04);
        `CHK("acc low", r.el, q);
        rd(ADDR_STATUS);
        `CHK("status", {20'h0, r.st[11:4], r.ef}, q);
        if (r.et[0]) exp_cause = r.et[2:1];
        rd(ADDR_TRAP);
        `CHK("trap reg", {29'h0, exp_cause, r.et[0]}, q);
        `CHK("trap pulses", 32'(r.et[0]), 32'(n_trap - t0));
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end
    initial begin
        presetn = 1'b0;
        num_errors = 0;
        n_tests = 0;
        n_trap = 0;
        exp_cause = CAUSE_NONE;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS);
        `CHK("status at reset", FPS_RESET, q);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // back-to-back subtracts
        wr(ADDR_AC_BASE, 32'h4140_0000);
        wr(ADDR_SRC_HI, 32'h4080_0000);
        wr(ADDR_STATUS, 32'h0);
        wr(ADDR_INSN, 32'h0000_F608);
        wr(ADDR_INSN, 32'h0000_F608);
        rd(ADDR_AC_BASE);
        `CHK("twice subtracted", 32'h4080_0000, q);
        // writable status bits, refused accesses
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS);
        `CHK("status bits", 32'h0000_0EAF, q);
        rd(8'h34);
        `CHK("unmapped data", 32'h0, q);
        `CHK("unmapped err", 1'b1, e);
        wr(ADDR_INSN, 32'h0);
        `CHK("bad opcode err", 1'b1, e);
        // reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("outputs in reset", 38'h0,
            {prdata, pready, pslverr, float_trap, float_trap_cause, unit_busy});
        presetn <= 1'b1;
        rd(ADDR_AC_BASE);
        `CHK("acc after reset", 32'h0, q);
        rd(ADDR_STATUS);
        `CHK("status after reset", FPS_RESET, q);
        give_verdict();
    end
endmodule
